// file: two_wire_ctrl.sv
// two-wire bus byte engine with its register slave
`timescale 1ns/1ps
`default_nettype none
module two_wire_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  tw_pkg::state_t q, d;
  logic scl_l, scl_p, sda_l, sda_p, tick, smp, start_det, stop_det;
  logic wr_go, ctrl_wr, data_wr, cfg_wr, si_clr;

  // ----------------------------------------------------------------
  // pin events and write decode
  // ----------------------------------------------------------------
  assign scl_l = q.scl2;
  assign scl_p = q.scl3;
  assign sda_l = q.sda2;
  assign sda_p = q.sda3;
  assign tick = (q.tmr == 8'h00);
  assign start_det = scl_l && scl_p && sda_p && !sda_l;
  assign stop_det = scl_l && scl_p && !sda_p && sda_l;
  // master samples at the end of its own high phase; a stretched clock delays it
  assign smp = q.c.master ? (tick && q.sclh && scl_l) : (scl_l && !scl_p);
  assign wr_go = q.awg && q.wg && !q.bv;
  assign ctrl_wr = wr_go && q.awa == tw_pkg::CTRL_OFS && q.ws[0];
  assign data_wr = wr_go && q.awa == tw_pkg::DATA_OFS && q.ws[0];
  assign cfg_wr = wr_go && q.awa == tw_pkg::CFG_OFS;
  assign si_clr = ctrl_wr && q.c.si && !q.wd[tw_pkg::SI_B];

  assign s_axi_awready = !q.awg && !q.bv;
  assign s_axi_wready = !q.wg && !q.bv;
  assign s_axi_bvalid = q.bv;
  assign s_axi_bresp = q.br;
  assign s_axi_arready = !q.rv;
  assign s_axi_rvalid = q.rv;
  assign s_axi_rdata = q.rd;
  assign s_axi_rresp = q.rr;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = q.scl_drv;
  assign sda_oe = q.sda_drv;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] nb;
    logic [31:0] rdv;
    logic want;
    nb = {q.data[6:0], sda_l};
    rdv = 32'h0000_0000;
    want = 1'b0;
    d = q;
    // pins pass two flops before anything looks at them
    d.scl1 = scl_i;
    d.scl2 = q.scl1;
    d.scl3 = q.scl2;
    d.sda1 = sda_i;
    d.sda2 = q.sda1;
    d.sda3 = q.sda2;
    d.tmr = tick ? tw_pkg::TMR_RELOAD : q.tmr - 8'h01;

    // register slave
    if (s_axi_awvalid && !q.awg && !q.bv) begin
      d.awg = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wg && !q.bv) begin
      d.wg = 1'b1;
      d.wd = s_axi_wdata;
      d.ws = s_axi_wstrb;
    end
    if (wr_go) begin
      d.awg = 1'b0;
      d.wg = 1'b0;
      d.bv = 1'b1;
      d.br = (q.awa == tw_pkg::CTRL_OFS || q.awa == tw_pkg::DATA_OFS || cfg_wr) ?
             tw_pkg::RESP_OKAY : tw_pkg::RESP_SLVERR;
    end
    if (q.bv && s_axi_bready) begin
      d.bv = 1'b0;
    end
    if (s_axi_arvalid && !q.rv) begin
      d.rv = 1'b1;
      d.rr = tw_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        tw_pkg::CTRL_OFS: rdv = {24'h00_0000, q.c};
        tw_pkg::DATA_OFS: rdv = {24'h00_0000, q.data};
        tw_pkg::CFG_OFS: rdv = {17'h0_0000, q.own, 5'h00, q.busy, q.slave_event_mask, q.en};
        default: d.rr = tw_pkg::RESP_SLVERR;
      endcase
      d.rd = rdv;
    end else if (q.rv && s_axi_rready) begin
      d.rv = 1'b0;
    end

    // software effects first, so hardware sets below win in the same cycle
    if (ctrl_wr) begin
      d.c.begin_request_flag = q.wd[tw_pkg::STA_B];
      d.c.halt_condition_flag = q.wd[tw_pkg::STO_B];
      d.c.ack = q.wd[tw_pkg::ACK_B];
      // software may only clear the byte event, never raise it
      d.c.si = q.c.si && q.wd[tw_pkg::SI_B];
    end
    if (si_clr) begin
      d.c.arbitration_loss_flag = 1'b0;
      if (q.ph == tw_pkg::P_BYTE && q.bc == 4'h0 && (q.c.master || q.adr)) begin
        d.c.transmit_direction_flag = q.wr;
        d.wr = 1'b0;
      end
    end
    if (data_wr) begin
      d.data = q.wd[7:0];
      d.wr = 1'b1;
    end
    if (cfg_wr) begin
      if (q.ws[0]) begin
        d.en = q.wd[tw_pkg::EN_B];
        d.slave_event_mask = q.wd[tw_pkg::INH_B];
      end
      if (q.ws[1]) begin
        d.own = q.wd[tw_pkg::OWN_LSB +: 7];
      end
    end

    if (!q.en) begin
      d.ph = tw_pkg::P_IDLE;
      d.sda_drv = 1'b0;
      d.scl_drv = 1'b0;
      d.sclh = 1'b0;
      d.c.master = 1'b0;
      d.adr = 1'b0;
    end else begin
      unique case (q.ph)
        tw_pkg::P_IDLE: begin
          d.sda_drv = 1'b0;
          d.scl_drv = 1'b0;
          if (q.c.begin_request_flag && !q.busy && !q.c.si && tick) begin
            d.ph = tw_pkg::P_START;
            d.st = 2'h0;
          end
        end
        tw_pkg::P_START: if (tick) begin
          // release sda, then scl, then pull sda and scl low in turn
          unique case (q.st)
            2'h0: begin d.sda_drv = 1'b0; d.st = 2'h1; end
            2'h1: begin d.scl_drv = 1'b0; d.st = 2'h2; end
            2'h2: begin
              if (!scl_l) begin
                d.c.arbitration_loss_flag = 1'b1;
                d.c.si = 1'b1;
                d.c.master = 1'b0;
                d.c.transmit_direction_flag = 1'b0;
                d.ph = tw_pkg::P_IDLE;
              end else begin
                d.sda_drv = 1'b1;
                d.busy = 1'b1;
                d.st = 2'h3;
              end
            end
            2'h3: begin
              d.scl_drv = 1'b1;
              d.sclh = 1'b0;
              d.c.master = 1'b1;
              d.c.transmit_direction_flag = 1'b1;
              d.c.si = 1'b1;
              d.wr = 1'b0;
              d.abyte = 1'b1;
              d.bc = 4'h0;
              d.ph = tw_pkg::P_BYTE;
            end
          endcase
        end
        tw_pkg::P_STOP: if (tick) begin
          unique case (q.st)
            2'h0: begin d.sda_drv = 1'b1; d.st = 2'h1; end
            2'h1: begin d.scl_drv = 1'b0; d.st = 2'h2; end
            2'h2: begin
              if (!scl_l) begin
                d.c.arbitration_loss_flag = 1'b1;
                d.c.si = 1'b1;
                d.c.master = 1'b0;
                d.c.transmit_direction_flag = 1'b0;
                d.ph = tw_pkg::P_IDLE;
              end else begin
                d.sda_drv = 1'b0;
                d.st = 2'h3;
              end
            end
            2'h3: begin
              d.c.halt_condition_flag = 1'b0;
              d.c.master = 1'b0;
              d.c.transmit_direction_flag = 1'b0;
              d.busy = 1'b0;
              d.ph = tw_pkg::P_IDLE;
            end
          endcase
        end
        tw_pkg::P_BYTE: begin
          want = (q.c.master || q.adr) && ((q.bc < 4'h8) ? (q.c.transmit_direction_flag && !q.data[7]) :
                 (!q.c.transmit_direction_flag && q.c.ack));
          // sda only moves while scl is low, so no false start or stop appears
          if (!scl_l) begin
            d.sda_drv = want;
          end
          if (!q.c.master) begin
            d.scl_drv = q.c.si && q.adr && (q.scl_drv || !scl_l);
          end else if (tick && !q.c.si) begin
            if (!q.sclh) begin
              if (q.bc == 4'h0 && !q.abyte && q.c.halt_condition_flag) begin
                d.ph = tw_pkg::P_STOP;
                d.st = 2'h0;
              end else if (q.bc == 4'h0 && !q.abyte && q.c.begin_request_flag) begin
                d.ph = tw_pkg::P_START;
                d.st = 2'h0;
              end else begin
                d.sclh = 1'b1;
                d.scl_drv = 1'b0;
              end
            end else if (scl_l) begin
              d.sclh = 1'b0;
              d.scl_drv = 1'b1;
            end
          end
          if (smp) begin
            if (q.bc != 4'h8) begin
              d.data = nb;
              d.bc = q.bc + 4'h1;
              if (q.c.transmit_direction_flag && q.data[7] && !sda_l) begin
                d.c.arbitration_loss_flag = 1'b1;
                d.c.si = 1'b1;
                d.c.master = 1'b0;
                d.c.transmit_direction_flag = 1'b0;
                d.sclh = 1'b0;
                d.scl_drv = 1'b0;
                d.sda_drv = 1'b0;
              end
              if (q.bc == 4'h7) begin
                d.abyte = 1'b0;
                if (!d.c.transmit_direction_flag && (d.c.master || q.adr)) begin
                  d.c.si = 1'b1;
                  d.c.ack_needed_flag = 1'b1;
                end else if (!d.c.master && !q.adr && q.abyte) begin
                  if (nb[7:1] == q.own && !q.slave_event_mask && !q.ign) begin
                    d.adr = 1'b1;
                    d.aack = 1'b1;
                    d.c.begin_request_flag = 1'b1;
                    d.c.si = 1'b1;
                    d.c.ack_needed_flag = 1'b1;
                    d.c.transmit_direction_flag = 1'b0;
                    d.wr = 1'b0;
                  end else begin
                    d.ph = tw_pkg::P_LISTEN;
                  end
                end
              end
            end else begin
              d.bc = 4'h0;
              if (q.c.transmit_direction_flag) begin
                d.c.ack = !sda_l;
                d.c.si = 1'b1;
              end else begin
                d.c.ack_needed_flag = 1'b0;
                d.aack = 1'b0;
                d.c.transmit_direction_flag = q.wr;
                d.wr = 1'b0;
                if (q.aack && !q.c.ack) begin
                  d.ign = 1'b1;
                  d.adr = 1'b0;
                  d.ph = tw_pkg::P_LISTEN;
                end
              end
            end
          end
        end
        tw_pkg::P_LISTEN: begin
          d.sda_drv = 1'b0;
          d.scl_drv = 1'b0;
        end
        default: d.ph = tw_pkg::P_IDLE;
      endcase

      if (start_det && q.ph != tw_pkg::P_START) begin
        d.ign = 1'b0;
        d.c.transmit_direction_flag = 1'b0;
        d.busy = 1'b1;
        d.bc = 4'h0;
        d.abyte = 1'b1;
        d.adr = 1'b0;
        d.aack = 1'b0;
        d.sda_drv = 1'b0;
        d.scl_drv = 1'b0;
        d.sclh = 1'b0;
        d.ph = tw_pkg::P_BYTE;
        if (q.c.master && !q.c.begin_request_flag) begin
          d.c.arbitration_loss_flag = 1'b1;
          d.c.si = 1'b1;
          d.c.master = 1'b0;
        end
      end
      if (stop_det && q.ph != tw_pkg::P_STOP) begin
        d.busy = 1'b0;
        d.ph = tw_pkg::P_IDLE;
        d.sda_drv = 1'b0;
        d.scl_drv = 1'b0;
        d.adr = 1'b0;
        d.c.transmit_direction_flag = 1'b0;
        if (q.adr || q.c.master) begin
          d.c.halt_condition_flag = 1'b1;
          d.c.si = 1'b1;
        end
        if (q.c.master) begin
          d.c.arbitration_loss_flag = 1'b1;
          d.c.master = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.c <= tw_pkg::CTRL_RST;
      q.own <= tw_pkg::OWN_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_stall_scl;
    q.en && q.ph == tw_pkg::P_BYTE && q.c.si && q.c.master |=> scl_oe;
  endproperty
  a_stall_scl: assert property (p_stall_scl) else $error("scl not held during byte event");

  property p_master_arb;
    $rose(q.c.arbitration_loss_flag) |-> !q.c.master;
  endproperty
  a_master_arb: assert property (p_master_arb) else $error("master kept after loss");

  property p_arb_si;
    $fell(q.c.si) |-> !q.c.arbitration_loss_flag;
  endproperty
  a_arb_si: assert property (p_arb_si) else $error("loss flag outlived byte event");

  property p_start_flags;
    $rose(q.c.master) |-> q.c.transmit_direction_flag && q.c.si;
  endproperty
  a_start_flags: assert property (p_start_flags) else $error("start flags wrong");

  property p_sta_keep;
    q.c.begin_request_flag && !ctrl_wr |=> q.c.begin_request_flag;
  endproperty
  a_sta_keep: assert property (p_sta_keep) else $error("begin request cleared by hw");

  property p_ack_needed_flag_si;
    $rose(q.c.ack_needed_flag) |-> q.c.si;
  endproperty
  a_ack_needed_flag_si: assert property (p_ack_needed_flag_si) else $error("ack needed without event");

  property p_ack_rec;
    q.en && q.ph == tw_pkg::P_BYTE && smp && q.bc == 4'h8 && q.c.transmit_direction_flag && !start_det
      && !stop_det |=> q.c.ack == !$past(sda_l);
  endproperty
  a_ack_rec: assert property (p_ack_rec) else $error("received ack not recorded");

  property p_ack_drv;
    q.en && q.ph == tw_pkg::P_BYTE && q.bc == 4'h8 && !q.c.transmit_direction_flag && (q.c.master || q.adr)
      && !scl_l && !start_det && !stop_det |=> sda_oe == $past(q.c.ack);
  endproperty
  a_ack_drv: assert property (p_ack_drv) else $error("ack level not driven");

  property p_shift;
    q.en && q.ph == tw_pkg::P_BYTE && smp && q.bc < 4'h8 && !data_wr
      |=> q.data[0] == $past(sda_l);
  endproperty
  a_shift: assert property (p_shift) else $error("bus bit not shifted in");

  property p_sto_done;
    q.en && q.ph == tw_pkg::P_STOP && q.st == 2'h3 && tick && !ctrl_wr |=> !q.c.halt_condition_flag;
  endproperty
  a_sto_done: assert property (p_sto_done) else $error("halt flag kept after stop");

  property p_start_go;
    q.en && q.ph == tw_pkg::P_IDLE && q.c.begin_request_flag && !q.busy && !q.c.si && tick && !start_det
      && !stop_det |=> q.ph == tw_pkg::P_START;
  endproperty
  a_start_go: assert property (p_start_go) else $error("free bus start not begun");

  property p_bv_hold;
    q.bv && !s_axi_bready |=> q.bv && $stable(q.br);
  endproperty
  a_bv_hold: assert property (p_bv_hold) else $error("write response dropped");

  c_master_start: cover property ($rose(q.c.master));
  c_arb_loss: cover property ($rose(q.c.arbitration_loss_flag));
  c_slave_hit: cover property ($rose(q.adr));
  c_stop_gen: cover property (q.ph == tw_pkg::P_STOP ##1 q.ph == tw_pkg::P_IDLE);
endmodule
`default_nettype wire

// file: tw_pkg.sv
// shared constants and types for the two-wire bus controller
package tw_pkg;
  localparam logic [7:0] CTRL_OFS = 8'hc0;
  localparam logic [7:0] DATA_OFS = 8'hc4;
  localparam logic [7:0] CFG_OFS = 8'hc8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [6:0] OWN_RST = 7'h00;
  localparam int SI_B = 0;
  localparam int ACK_B = 1;
  localparam int STO_B = 4;
  localparam int STA_B = 5;
  localparam int EN_B = 0;
  localparam int INH_B = 1;
  localparam int OWN_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_NS = 100;
  localparam int HALF_NS = 5000;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] TMR_RELOAD = 8'(HALF_CYC - 1);

  typedef enum logic [2:0] {
    P_IDLE = 3'h0,
    P_START = 3'h1,
    P_BYTE = 3'h3,
    P_STOP = 3'h2,
    P_LISTEN = 3'h6
  } phase_t;

  typedef struct packed {
    logic master;
    logic transmit_direction_flag;
    logic begin_request_flag;
    logic halt_condition_flag;
    logic ack_needed_flag;
    logic arbitration_loss_flag;
    logic ack;
    logic si;
  } ctrl_t;

  typedef struct packed {
    ctrl_t c;
    logic [7:0] data;
    logic en, slave_event_mask;
    logic [6:0] own;
    logic busy, ign, adr, aack, wr, abyte, sclh, scl_drv, sda_drv;
    phase_t ph;
    logic [3:0] bc;
    logic [1:0] st;
    logic [7:0] tmr;
    logic scl1, scl2, scl3, sda1, sda2, sda3;
    logic awg, wg, bv, rv;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [1:0] br, rr;
    logic [31:0] rd;
  } state_t;
endpackage

// file: tw_partner.sv
// behavioural far-side party on the two-wire bus: byte responder and clocking master
`timescale 1ns/1ps
`default_nettype none
module tw_partner (
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  // ----------------------------------------
  // responder: acknowledges every byte it is clocked
  // ----------------------------------------
  logic [7:0] sh = 8'h00;
  logic [7:0] got[$];
  int nb = 0;
  int nstop = 0;
  logic act = 1'h0;
  logic mst = 1'h0;
  initial begin
    scl_pull = 1'h0;
    sda_pull = 1'h0;
  end
  always @(negedge sda) begin
    if (scl === 1'h1 && !mst) begin
      act = 1'h1;
      nb = 0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'h1 && act) begin
      act = 1'h0;
      nstop++;
    end
  end
  always @(posedge scl) begin
    if (act && nb < 8) begin
      sh = {sh[6:0], sda};
      nb++;
    end
  end
  always @(negedge scl) begin
    if (act && nb == 8) begin
      got.push_back(sh);
      sda_pull = 1'h1;
      nb = 9;
    end else if (act && nb == 9) begin
      sda_pull = 1'h0;
      nb = 0;
    end
  end
  // ----------------------------------------
  // master: 800 ns bit period, clock released between frames
  // ----------------------------------------
  task automatic mstart;
    mst = 1'h1;
    sda_pull = 1'h1;
    #400;
    scl_pull = 1'h1;
  endtask
  task automatic mbit(input logic b, output logic r);
    #100;
    sda_pull = !b;
    #300;
    scl_pull = 1'h0;
    // a stretched clock must be waited out, not overrun
    wait (scl === 1'h1);
    #400;
    r = sda;
    scl_pull = 1'h1;
  endtask
  task automatic mbyte(input logic [7:0] b, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      mbit(b[i], r);
    end
    mbit(1'h1, ak);
  endtask
  task automatic mstop;
    #100;
    sda_pull = 1'h1;
    #300;
    scl_pull = 1'h0;
    wait (scl === 1'h1);
    #400;
    sda_pull = 1'h0;
    #400;
    mst = 1'h0;
  endtask
endmodule
`default_nettype wire

// file: tb_two_wire_bus_control_and_transfer.sv
// self-checking bench for the two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
module tb_two_wire_bus_control_and_transfer;
  logic aclk;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, scl_pull, sda_pull;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int seed = 58;
  int n_tests = 0;
  int n_mismatch = 0;
  wire scl = !(scl_oe | scl_pull);
  wire sda = !(sda_oe | sda_pull);

  two_wire_ctrl two_wire_ctrl_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  tw_partner tw_partner_i (.scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull));

  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end
  // ----------------------------------------
  // bus tasks and comparisons
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] cv(input int m, t, sa, so, rq, al, ak, si);
    return {24'h0, m[0], t[0], sa[0], so[0], rq[0], al[0], ak[0], si[0]};
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        r = bresp;
        bready <= 1'h0;
        break;
      end
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        break;
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk_resp(r, tw_pkg::RESP_OKAY);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk_resp(r, tw_pkg::RESP_OKAY);
    chk(d & m, e);
  endtask
  task automatic wait_si;
    logic [31:0] d;
    logic [1:0] r;
    do begin
      axr(tw_pkg::CTRL_OFS, d, r);
    end while (d[0] !== 1'h1);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] a;
    logic [7:0] b;
    logic [6:0] o;
    logic k1, k2;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rd_chk(tw_pkg::CTRL_OFS, 32'hffffffff, 32'h0);
    rd_chk(tw_pkg::DATA_OFS, 32'hffffffff, 32'h0);
    axr(8'h10, d, r);
    chk_resp(r, tw_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    axw(8'h10, 32'hffffffff, r);
    chk_resp(r, tw_pkg::RESP_SLVERR);
    // status bits are read-only and the event flag can only be cleared
    wr(tw_pkg::CTRL_OFS, 32'hcd);
    rd_chk(tw_pkg::CTRL_OFS, 32'hff, 32'h0);
    o = 7'($random(seed)) | 7'h01;
    wr(tw_pkg::CFG_OFS, {17'h0, o, 8'h01});
    $display("test registers done");
    wr(tw_pkg::CTRL_OFS, 32'h20);
    wait_si();
    rd_chk(tw_pkg::CTRL_OFS, 32'hff, cv(1, 1, 1, 0, 0, 0, 0, 1));
    a = {7'($random(seed)), 1'h0};
    for (int i = 0; i < 3; i++) begin
      wr(tw_pkg::DATA_OFS, {24'h0, a});
      wr(tw_pkg::CTRL_OFS, 32'h0);
      wait_si();
      rd_chk(tw_pkg::CTRL_OFS, 32'hff, cv(1, 1, 0, 0, 0, 0, 1, 1));
      rd_chk(tw_pkg::DATA_OFS, 32'hff, {24'h0, a});
      chk({24'h0, tw_partner_i.got[i]}, {24'h0, a});
      a = 8'($random(seed));
    end
    wr(tw_pkg::CTRL_OFS, 32'h10);
    do begin
      axr(tw_pkg::CTRL_OFS, d, r);
    end while (d[7] !== 1'h0);
    rd_chk(tw_pkg::CTRL_OFS, 32'h91, 32'h0);
    $display("test master_write done");
    b = 8'($random(seed));
    fork
      begin
        tw_partner_i.mstart();
        tw_partner_i.mbyte({o, 1'h0}, k1);
        tw_partner_i.mbyte(b, k2);
        tw_partner_i.mstop();
      end
      begin
        wait_si();
        rd_chk(tw_pkg::CTRL_OFS, 32'hfd, cv(0, 0, 1, 0, 1, 0, 0, 1));
        wr(tw_pkg::CTRL_OFS, 32'h02);
        wait_si();
        rd_chk(tw_pkg::CTRL_OFS, 32'hfd, cv(0, 0, 0, 0, 1, 0, 0, 1));
        rd_chk(tw_pkg::DATA_OFS, 32'hff, {24'h0, b});
        wr(tw_pkg::CTRL_OFS, 32'h0);
        wait_si();
        rd_chk(tw_pkg::CTRL_OFS, 32'hfd, cv(0, 0, 0, 1, 0, 0, 0, 1));
        wr(tw_pkg::CTRL_OFS, 32'h0);
      end
    join
    chk({31'h0, k1}, 32'h0);
    chk({31'h0, k2}, 32'h1);
    chk(32'(tw_partner_i.nstop), 32'h1);
    $display("test slave_receive done");
    // read address: software walks the receive-to-transmit steps, master nacks one byte
    fork
      begin
        tw_partner_i.mstart();
        tw_partner_i.mbyte({o, 1'h1}, k1);
        for (int i = 7; i >= 0; i--) begin
          tw_partner_i.mbit(1'h1, b[i]);
        end
        tw_partner_i.mbit(1'h1, k2);
        tw_partner_i.mstop();
      end
      begin
        wait_si();
        wr(tw_pkg::CTRL_OFS, 32'h03);
        a = 8'($random(seed));
        wr(tw_pkg::DATA_OFS, {24'h0, a});
        if (!a[7]) begin
          wr(tw_pkg::CTRL_OFS, 32'h13);
          wr(tw_pkg::CTRL_OFS, 32'h12);
          do begin
            axr(tw_pkg::CTRL_OFS, d, r);
          end while (d[6] !== 1'h1);
          wr(tw_pkg::CTRL_OFS, 32'h02);
        end else begin
          wr(tw_pkg::CTRL_OFS, 32'h02);
        end
        wait_si();
        rd_chk(tw_pkg::CTRL_OFS, 32'hff, cv(0, 1, 0, 0, 0, 0, 0, 1));
        // no data write after a nack, only the event clear
        wr(tw_pkg::CTRL_OFS, 32'h0);
        wait_si();
        rd_chk(tw_pkg::CTRL_OFS, 32'hfd, cv(0, 0, 0, 1, 0, 0, 0, 1));
        wr(tw_pkg::CTRL_OFS, 32'h0);
      end
    join
    chk({24'h0, b}, {24'h0, a});
    chk({31'h0, k1}, 32'h0);
    chk({31'h0, k2}, 32'h1);
    $display("test slave_transmit done");
    fork
      begin
        tw_partner_i.mstart();
        tw_partner_i.mbyte({o, 1'h0}, k1);
        tw_partner_i.mbyte(8'($random(seed)), k2);
        tw_partner_i.mstop();
      end
      begin
        wait_si();
        wr(tw_pkg::CTRL_OFS, 32'h0);
      end
    join
    rd_chk(tw_pkg::CTRL_OFS, 32'h01, 32'h0);
    chk({31'h0, k1}, 32'h1);
    chk({31'h0, k2}, 32'h1);
    $display("test slave_nack done");
    finish_test();
  end
  // about seven times the expected run of roughly four thousand cycles
  initial begin
    #3000000;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
